// ---- hdl/pll_link_pkg.sv ----
// Shared constants for the serial synthesizer control link and its host
`default_nettype none
package pll_link_pkg;
    // ========================================================
    // Serial word and register select
    localparam int          WORD_W       = 24;
    localparam int          SEL_W        = 3;
    localparam int          NUM_REGS     = 8;
    localparam logic [2:0]  REG_CHANNEL  = 3'h0;
    localparam logic [2:0]  REG_MODULUS  = 3'h1;
    localparam logic [2:0]  REG_PHASE    = 3'h2;
    localparam logic [2:0]  REG_TIMER    = 3'h4;
    localparam logic [2:0]  REG_MONITOR  = 3'h6;
    // ========================================================
    // Field layouts
    localparam int          INT_LSB      = 15;
    localparam int          INT_W        = 8;
    localparam int          NUM_LSB      = 3;
    localparam int          NUM_W        = 12;
    localparam int          MODCFG_LSB   = 3;
    localparam int          MODCFG_W     = 21;
    localparam int          PHASE_LSB    = 3;
    localparam int          PHASE_W      = 12;
    localparam int          TO_LSB       = 5;
    localparam int          TO_W         = 9;
    localparam int          TSEL_LSB     = 3;
    localparam int          TSEL_W       = 2;
    localparam int          MON_LSB      = 3;
    localparam int          MON_W        = 4;
    localparam int          THRESH_BIT   = 15;
    localparam logic [1:0]  TSEL_PUMP    = 2'h0;
    localparam logic [1:0]  TSEL_SW_AB   = 2'h1;
    localparam logic [1:0]  TSEL_SW_C    = 2'h2;
    localparam logic [8:0]  TO_RESET     = 9'h010;
    // ========================================================
    // Fast lock and lock detect
    localparam int          CELLS_W      = 7;
    localparam logic [6:0]  CELLS_ALL    = 7'h40;
    localparam logic [6:0]  CELLS_ONE    = 7'h01;
    localparam int          TDIV_W       = 2;
    localparam logic [1:0]  TDIV_LAST    = 2'h3;
    localparam int          TCNT_W       = 10;
    localparam int          LOCK_W       = 6;
    localparam logic [5:0]  LOCK_CYCLES  = 6'h28;
    localparam int          ERR_W        = 8;
    localparam logic [7:0]  ERR_FINE_NS  = 8'h03;
    localparam logic [7:0]  ERR_WIDE_NS  = 8'h0A;
    localparam logic [7:0]  ERR_LOSS_NS  = 8'h1E;
    localparam logic [3:0]  MON_LOW      = 4'h0;
    localparam logic [3:0]  MON_HIGH     = 4'h1;
    localparam logic [3:0]  MON_LOCK     = 4'h2;
    localparam logic [3:0]  MON_FAST     = 4'h3;
    localparam logic [3:0]  MON_PFD      = 4'h4;
    localparam logic [3:0]  MON_TICK     = 4'h5;
    // ========================================================
    // Host timing and register map
    localparam int          CLK_PERIOD_NS  = 8;
    localparam int          LINK_PERIOD_NS = 160;
    localparam int          HALF_W         = 8;
    localparam logic [7:0]  HALF_CYCLES    =
        8'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));
    localparam logic [4:0]  BIT_LAST       = 5'h17;
    localparam logic [31:0] OFS_DATA       = 32'h0000_0000;
    localparam logic [31:0] OFS_STATUS     = 32'h0000_0004;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : pll_link_pkg
`default_nettype wire

// ---- hdl/pll_link_if.sv ----
// Three-wire programming link between host and synthesizer control core
`default_nettype none
interface pll_link_if;
    logic serial_clk;
    logic serial_data;
    logic latch_strobe;

    modport host (
        output serial_clk,
        output serial_data,
        output latch_strobe
    );
    modport device (
        input  serial_clk,
        input  serial_data,
        input  latch_strobe
    );
endinterface : pll_link_if
`default_nettype wire

// ---- hdl/pll_serial_fastlock_ctrl.sv ----
// Synthesizer control core: serial register load, fast lock, lock detect
// ============================================================
`default_nettype none
module pll_serial_fastlock_ctrl (
    // Clock and reset
    input  wire logic                CLOCK_I,
    input  wire logic                RST_I,
    // Programming link
    pll_link_if.device               link,
    // Phase detector side
    input  wire logic                PFD_REF_I,
    input  wire logic [7:0]          PHASE_ERR_NS_I,
    // Divider settings in force
    output logic      [7:0]          INT_VALUE_O,
    output logic      [11:0]         NUMERATOR_O,
    output logic      [20:0]         MODULUS_CFG_O,
    output logic      [11:0]         PHASE_SEED_O,
    // Fast lock controls
    output logic      [6:0]          PUMP_CELLS_O,
    output logic                     FILTER_SWITCH_A_O,
    output logic                     FILTER_SWITCH_B_O,
    output logic                     FILTER_SWITCH_C_O,
    // Status
    output logic                     LOCK_O,
    output logic                     MONITOR_O
);
    typedef enum logic [3:0] {
        FL_IDLE = 4'b0001,
        FL_WIDE = 4'b0010,
        FL_STEP = 4'b0100,
        FL_DONE = 4'b1000
    } fl_state_t;

    // ========================================================
    // Synchronisers for the link wires, the reference and the phase error; RST_I is used directly as an async reset
    logic [2:0] sclk_q, sdat_q, latch_q, pfd_q;
    logic [7:0] err_s1_q, err_s2_q;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            sclk_q   <= 3'h0;
            sdat_q   <= 3'h0;
            latch_q  <= 3'h0;
            pfd_q    <= 3'h0;
            err_s1_q <= 8'h00;
            err_s2_q <= 8'h00;
        end else begin
            sclk_q   <= {sclk_q[1:0], link.serial_clk};
            sdat_q   <= {sdat_q[1:0], link.serial_data};
            latch_q  <= {latch_q[1:0], link.latch_strobe};
            pfd_q    <= {pfd_q[1:0], PFD_REF_I};
            err_s1_q <= PHASE_ERR_NS_I;
            err_s2_q <= err_s1_q;
        end
    end

    // Bit 0 of each chain is the raw first stage and is never read here
    logic sclk_rise, latch_rise, pfd_rise, pfd_fall;
    assign sclk_rise  = sclk_q[1] & ~sclk_q[2];
    assign latch_rise = latch_q[1] & ~latch_q[2];
    assign pfd_rise   = pfd_q[1] & ~pfd_q[2];
    assign pfd_fall   = ~pfd_q[1] & pfd_q[2];

    // ========================================================
    // Serial shift register and register load
    logic [23:0] shift_q;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            shift_q <= 24'h000000;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[22:0], sdat_q[1]};
        end
    end

    function automatic logic sel_is(input logic [23:0] w,
                                    input logic [2:0]  idx);
        sel_is = (w[pll_link_pkg::SEL_W-1:0] == idx);
    endfunction : sel_is

    logic load_chan, load_mod, load_phase, load_timer, load_mon;
    assign load_chan  = latch_rise &
        sel_is(shift_q, pll_link_pkg::REG_CHANNEL);
    assign load_mod   = latch_rise &
        sel_is(shift_q, pll_link_pkg::REG_MODULUS);
    assign load_phase = latch_rise &
        sel_is(shift_q, pll_link_pkg::REG_PHASE);
    assign load_timer = latch_rise &
        sel_is(shift_q, pll_link_pkg::REG_TIMER);
    assign load_mon   = latch_rise &
        sel_is(shift_q, pll_link_pkg::REG_MONITOR);

    // Words for registers three, five and seven have no load strobe and are dropped
    logic [23:0] chan_word_q, mod_shadow_q, phase_shadow_q, monitor_word_q;
    logic [8:0]  to_pump_q, to_sw_ab_q, to_sw_c_q;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            chan_word_q    <= 24'h000000;
            mod_shadow_q   <= 24'h000000;
            phase_shadow_q <= 24'h000000;
            monitor_word_q <= 24'h000000;
        end else begin
            if (load_chan)  chan_word_q    <= shift_q;
            if (load_mod)   mod_shadow_q   <= shift_q;
            if (load_phase) phase_shadow_q <= shift_q;
            if (load_mon)   monitor_word_q <= shift_q;
        end
    end

    logic [1:0] tsel;
    logic [8:0] to_val;
    assign tsel   = shift_q[pll_link_pkg::TSEL_LSB +: pll_link_pkg::TSEL_W];
    assign to_val = shift_q[pll_link_pkg::TO_LSB +: pll_link_pkg::TO_W];

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            to_pump_q  <= pll_link_pkg::TO_RESET;
            to_sw_ab_q <= pll_link_pkg::TO_RESET;
            to_sw_c_q  <= pll_link_pkg::TO_RESET;
        end else if (load_timer) begin
            if (tsel == pll_link_pkg::TSEL_PUMP) begin
                to_pump_q <= to_val;
            end else if (tsel == pll_link_pkg::TSEL_SW_AB) begin
                to_sw_ab_q <= to_val;
            end else if (tsel == pll_link_pkg::TSEL_SW_C) begin
                to_sw_c_q <= to_val;
            end
        end
    end

    // ========================================================
    // Apply a channel write on the next detector cycle
    logic pend_q, apply;
    assign apply = pend_q & pfd_rise;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            pend_q <= 1'b0;
        end else if (load_chan) begin
            pend_q <= 1'b1;
        end else if (apply) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            INT_VALUE_O   <= 8'h00;
            NUMERATOR_O   <= 12'h000;
            MODULUS_CFG_O <= 21'h000000;
            PHASE_SEED_O  <= 12'h000;
        end else if (apply) begin
            INT_VALUE_O   <= chan_word_q[pll_link_pkg::INT_LSB +:
                                         pll_link_pkg::INT_W];
            NUMERATOR_O   <= chan_word_q[pll_link_pkg::NUM_LSB +:
                                         pll_link_pkg::NUM_W];
            MODULUS_CFG_O <= mod_shadow_q[pll_link_pkg::MODCFG_LSB +:
                                          pll_link_pkg::MODCFG_W];
            PHASE_SEED_O  <= phase_shadow_q[pll_link_pkg::PHASE_LSB +:
                                            pll_link_pkg::PHASE_W];
        end
    end

    // ========================================================
    // Timer clock: falling reference edges divided by four
    logic [1:0] tdiv_q;
    logic       tick;
    assign tick = pfd_fall & (tdiv_q == pll_link_pkg::TDIV_LAST);

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            tdiv_q <= 2'h0;
        end else if (pfd_fall) begin
            tdiv_q <= tdiv_q + 2'h1;
        end
    end

    // ========================================================
    // Fast lock sequencer
    fl_state_t   fl_q;
    logic [9:0]  tcnt_q;
    logic        fast;
    assign fast = (fl_q == FL_WIDE) | (fl_q == FL_STEP);

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            tcnt_q <= 10'h000;
        end else if (apply) begin
            tcnt_q <= 10'h000;
        end else if (tick && tcnt_q != 10'h3FF) begin
            tcnt_q <= tcnt_q + 10'h001;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            fl_q         <= FL_IDLE;
            PUMP_CELLS_O <= pll_link_pkg::CELLS_ONE;
        end else if (apply) begin
            fl_q         <= FL_WIDE;
            PUMP_CELLS_O <= pll_link_pkg::CELLS_ALL;
        end else if (tick) begin
            case (fl_q)
                FL_WIDE: begin
                    if (tcnt_q >= {1'b0, to_pump_q}) begin
                        fl_q <= FL_STEP;
                    end
                end
                FL_STEP: begin
                    PUMP_CELLS_O <= PUMP_CELLS_O >> 1;
                    if (PUMP_CELLS_O == (pll_link_pkg::CELLS_ONE << 1)) begin
                        fl_q <= FL_DONE;
                    end
                end
                default: begin
                    fl_q <= fl_q;
                end
            endcase
        end
    end

    // Late switch timeouts keep the filter wide until the steps finish
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            FILTER_SWITCH_A_O <= 1'b0;
            FILTER_SWITCH_B_O <= 1'b0;
            FILTER_SWITCH_C_O <= 1'b0;
        end else if (apply) begin
            FILTER_SWITCH_A_O <= 1'b1;
            FILTER_SWITCH_B_O <= 1'b1;
            FILTER_SWITCH_C_O <= 1'b1;
        end else if (tick) begin
            if (tcnt_q >= {1'b0, to_sw_ab_q}) begin
                FILTER_SWITCH_A_O <= 1'b0;
                FILTER_SWITCH_B_O <= 1'b0;
            end
            if (tcnt_q >= {1'b0, to_sw_c_q}) begin
                FILTER_SWITCH_C_O <= 1'b0;
            end
        end
    end

    // ========================================================
    // Digital lock detect, one decision per detector cycle
    logic [5:0] good_q;
    logic [7:0] thresh;
    assign thresh = monitor_word_q[pll_link_pkg::THRESH_BIT] ?
                    pll_link_pkg::ERR_WIDE_NS :
                    pll_link_pkg::ERR_FINE_NS;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            good_q <= 6'h00;
            LOCK_O <= 1'b0;
        end else if (apply) begin
            good_q <= 6'h00;
            LOCK_O <= 1'b0;
        end else if (pfd_rise) begin
            if (err_s2_q > pll_link_pkg::ERR_LOSS_NS) begin
                good_q <= 6'h00;
                LOCK_O <= 1'b0;
            end else if (err_s2_q < thresh) begin
                if (good_q != pll_link_pkg::LOCK_CYCLES) begin
                    good_q <= good_q + 6'h01;
                end
                if (good_q == pll_link_pkg::LOCK_CYCLES - 6'h01) begin
                    LOCK_O <= 1'b1;
                end
            end else begin
                good_q <= 6'h00;
            end
        end
    end

    // ========================================================
    // Monitor output select
    logic [3:0] mon_sel;
    assign mon_sel = monitor_word_q[pll_link_pkg::MON_LSB +:
                                    pll_link_pkg::MON_W];

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            MONITOR_O <= 1'b0;
        end else if (mon_sel == pll_link_pkg::MON_HIGH) begin
            MONITOR_O <= 1'b1;
        end else if (mon_sel == pll_link_pkg::MON_LOCK) begin
            MONITOR_O <= LOCK_O;
        end else if (mon_sel == pll_link_pkg::MON_FAST) begin
            MONITOR_O <= fast;
        end else if (mon_sel == pll_link_pkg::MON_PFD) begin
            MONITOR_O <= pfd_q[2];
        end else if (mon_sel == pll_link_pkg::MON_TICK) begin
            MONITOR_O <= tick;
        end else begin
            MONITOR_O <= 1'b0;
        end
    end
endmodule : pll_serial_fastlock_ctrl
`default_nettype wire

// ---- hdl/pll_link_host.sv ----
// AXI4-Lite controlled host that shifts words out over the programming link
`default_nettype none
module pll_link_host (
    // Clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RST_I,
    // AXI4-Lite write address and data
    input  wire logic        AWVALID_I,
    output logic             AWREADY_O,
    input  wire logic [31:0] AWADDR_I,
    input  wire logic        WVALID_I,
    output logic             WREADY_O,
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  WSTRB_I,
    // AXI4-Lite write response
    output logic             BVALID_O,
    input  wire logic        BREADY_I,
    output logic [1:0]       BRESP_O,
    // AXI4-Lite read
    input  wire logic        ARVALID_I,
    output logic             ARREADY_O,
    input  wire logic [31:0] ARADDR_I,
    output logic             RVALID_O,
    input  wire logic        RREADY_I,
    output logic [31:0]      RDATA_O,
    output logic [1:0]       RRESP_O,
    // Programming link
    pll_link_if.host         link
);
    typedef enum logic [2:0] {
        HS_IDLE  = 3'b001,
        HS_SHIFT = 3'b010,
        HS_LATCH = 3'b100
    } host_state_t;

    // ========================================================
    // Write channel capture; address and data in either order
    logic        aw_got_q, w_got_q, busy;
    logic [31:0] aw_addr_q;
    logic [23:0] w_data_q, word_q;
    logic        do_write, start;
    host_state_t hs_q;

    assign busy      = (hs_q != HS_IDLE);
    assign AWREADY_O = ~aw_got_q & ~BVALID_O;
    assign WREADY_O  = ~w_got_q & ~BVALID_O;
    assign do_write  = aw_got_q & w_got_q & ~BVALID_O;
    assign start     = do_write & (aw_addr_q == pll_link_pkg::OFS_DATA) &
                       ~busy;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
            w_data_q  <= 24'h000000;
        end else if (do_write) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
        end else begin
            if (AWVALID_I && AWREADY_O) begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= AWADDR_I;
            end
            if (WVALID_I && WREADY_O) begin
                w_got_q  <= 1'b1;
                w_data_q <= WDATA_I[23:0];
            end
        end
    end

    // Writes while a word is in flight are refused, not queued
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            BVALID_O <= 1'b0;
            BRESP_O  <= pll_link_pkg::RESP_OKAY;
        end else if (do_write) begin
            BVALID_O <= 1'b1;
            BRESP_O  <= start ? pll_link_pkg::RESP_OKAY :
                                pll_link_pkg::RESP_SLVERR;
        end else if (BREADY_I) begin
            BVALID_O <= 1'b0;
        end
    end

    // ========================================================
    // Read channel
    assign ARREADY_O = ~RVALID_O;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            RVALID_O <= 1'b0;
            RDATA_O  <= 32'h0000_0000;
            RRESP_O  <= pll_link_pkg::RESP_OKAY;
        end else if (ARVALID_I && ARREADY_O) begin
            RVALID_O <= 1'b1;
            if (ARADDR_I == pll_link_pkg::OFS_DATA) begin
                RDATA_O <= {8'h00, word_q};
                RRESP_O <= pll_link_pkg::RESP_OKAY;
            end else if (ARADDR_I == pll_link_pkg::OFS_STATUS) begin
                RDATA_O <= {31'h0000_0000, busy};
                RRESP_O <= pll_link_pkg::RESP_OKAY;
            end else begin
                RDATA_O <= 32'h0000_0000;
                RRESP_O <= pll_link_pkg::RESP_SLVERR;
            end
        end else if (RREADY_I) begin
            RVALID_O <= 1'b0;
        end
    end

    // ========================================================
    // Half-period enable for the generated serial clock
    logic [7:0] div_q;
    logic       half;
    assign half = (div_q == pll_link_pkg::HALF_CYCLES - 8'h01);

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            div_q <= 8'h00;
        end else if (start || half) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // ========================================================
    // Shifter: data changes on the falling half, MSB first
    logic [4:0] bit_q;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            hs_q              <= HS_IDLE;
            word_q            <= 24'h000000;
            bit_q             <= 5'h00;
            link.serial_clk   <= 1'b0;
            link.serial_data  <= 1'b0;
            link.latch_strobe <= 1'b0;
        end else begin
            case (hs_q)
                HS_IDLE: begin
                    if (start) begin
                        hs_q             <= HS_SHIFT;
                        word_q           <= w_data_q;
                        bit_q            <= 5'h00;
                        link.serial_data <= w_data_q[23];
                    end
                end
                HS_SHIFT: begin
                    if (half && !link.serial_clk) begin
                        link.serial_clk <= 1'b1;
                    end else if (half) begin
                        link.serial_clk <= 1'b0;
                        bit_q           <= bit_q + 5'h01;
                        if (bit_q == pll_link_pkg::BIT_LAST) begin
                            hs_q <= HS_LATCH;
                        end else begin
                            link.serial_data <=
                                word_q[pll_link_pkg::BIT_LAST - bit_q - 5'h01];
                        end
                    end
                end
                HS_LATCH: begin
                    if (half && !link.latch_strobe) begin
                        link.latch_strobe <= 1'b1;
                    end else if (half) begin
                        link.latch_strobe <= 1'b0;
                        hs_q              <= HS_IDLE;
                    end
                end
                default: begin
                    hs_q <= HS_IDLE;
                end
            endcase
        end
    end
endmodule : pll_link_host
`default_nettype wire

// ---- dv/pll_link_chk.sv ----
// Wire checker for the three-wire programming link
`default_nettype none
module pll_link_chk (
    // Clock, reset and link wires
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic latch_strobe
);
    logic [5:0] bits_q;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    // ========================================
    // Clock pulses of the word in flight
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I)
            bits_q <= 6'h00;
        else if (latch_strobe)
            bits_q <= 6'h00;
        else if ($rose(serial_clk))
            bits_q <= bits_q + 6'h01;
    end
    // ========================================
    // Link framing
    a_data_steady: assert property (serial_clk |-> $stable(serial_data))
        else $error("data moved while clock high");
    a_clk_high_ten: assert property ($rose(serial_clk) |-> ##10 $fell(serial_clk))
        else $error("clock high time wrong");
    a_word_bits: assert property ($rose(latch_strobe) |-> bits_q == 6'h18)
        else $error("strobe before full word");
    a_strobe_gap: assert property ($rose(latch_strobe) |-> $past(serial_clk, 11) && !$past(serial_clk, 10))
        else $error("strobe not one half after fall");
    a_strobe_width: assert property ($rose(latch_strobe) |-> ##10 $fell(latch_strobe))
        else $error("strobe width wrong");
    a_strobe_clk_low: assert property (latch_strobe |-> !serial_clk)
        else $error("clock high during strobe");
endmodule : pll_link_chk
`default_nettype wire

// ---- dv/tb_top.sv ----
// Bench: AXI4-Lite host shifting words into the control core
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic c = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0;
    logic arv = 1'b0, rr = 1'b0, awr, wrr, bv, arr, rv, swa, swb, swc, lk_o;
    logic mon;
    logic [31:0] aw = 32'h0, wd = 32'h0, ara = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [3:0]  pc = 4'h0;
    logic [7:0]  err = 8'h01, intv;
    logic [11:0] num, seed;
    logic [20:0] modc;
    logic [6:0]  cells;
    int num_errors = 0, num_checks = 0;
    pll_link_if lk();
    pll_link_host pll_link_host_inst (.CLOCK_I(c), .RST_I(rst),
        .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(aw), .WVALID_I(wv),
        .WREADY_O(wrr), .WDATA_I(wd), .WSTRB_I(4'hF), .BVALID_O(bv),
        .BREADY_I(br), .BRESP_O(bresp), .ARVALID_I(arv), .ARREADY_O(arr),
        .ARADDR_I(ara), .RVALID_O(rv), .RREADY_I(rr), .RDATA_O(rdata),
        .RRESP_O(rresp), .link(lk));
    pll_serial_fastlock_ctrl pll_serial_fastlock_ctrl_inst (.CLOCK_I(c),
        .RST_I(rst), .link(lk), .PFD_REF_I(pc[3]), .PHASE_ERR_NS_I(err),
        .INT_VALUE_O(intv), .NUMERATOR_O(num), .MODULUS_CFG_O(modc),
        .PHASE_SEED_O(seed), .PUMP_CELLS_O(cells), .FILTER_SWITCH_A_O(swa),
        .FILTER_SWITCH_B_O(swb), .FILTER_SWITCH_C_O(swc), .LOCK_O(lk_o),
        .MONITOR_O(mon));
    pll_link_chk pll_link_chk_inst (.CLOCK_I(c), .RST_I(rst),
        .serial_clk(lk.serial_clk), .serial_data(lk.serial_data),
        .latch_strobe(lk.latch_strobe));
    always #4 c = ~c;
    // Reference period of 16 clocks gives a timer tick every 64
    always @(posedge c) pc <= pc + 4'h1;
    task chk(input string n, input logic [63:0] s, e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [31:0] a, d, input logic [1:0] e);
        logic pa, pw, ta, tw;
        logic [1:0] resp;
        @(posedge c);
        {awv, wv, br, aw, wd} <= {3'h7, a, d};
        {pa, pw} = 2'h3;
        while (pa | pw) begin
            @(negedge c);
            {ta, tw} = {pa & awr, pw & wrr};
            @(posedge c);
            {awv, wv} <= {pa & ~ta, pw & ~tw};
            {pa, pw} = {pa & ~ta, pw & ~tw};
        end
        do begin
            @(negedge c);
            {ta, resp} = {bv, bresp};
            @(posedge c);
        end while (!ta);
        br <= 1'b0;
        chk("bresp", resp, e);
    endtask : wr
    task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic t;
        @(posedge c);
        {arv, rr, ara} <= {2'h3, a};
        do begin
            @(negedge c);
            t = arr;
            @(posedge c);
        end while (!t);
        arv <= 1'b0;
        do begin
            @(negedge c);
            {t, d, r} = {rv, rdata, rresp};
            @(posedge c);
        end while (!t);
        rr <= 1'b0;
    endtask : rd
    // Busy poll; status bit 0 clears with the strobe fall
    task idle;
        logic [31:0] d;
        logic [1:0] r;
        do rd(pll_link_pkg::OFS_STATUS, d, r); while (d[0] !== 1'b0);
    endtask : idle
    task snd(input logic [23:0] w);
        wr(pll_link_pkg::OFS_DATA, {8'h00, w}, pll_link_pkg::RESP_OKAY);
        idle();
    endtask : snd
    task tally_and_finish;
        if (num_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        #400000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (3) @(posedge c);
        rst <= 1'b0;
        snd(24'hABCDE9);
        wr(pll_link_pkg::OFS_DATA, 32'h55E2, pll_link_pkg::RESP_OKAY);
        wr(pll_link_pkg::OFS_DATA, 32'h0, pll_link_pkg::RESP_SLVERR);
        idle();
        // Switch timeouts seven past the pump timeout
        snd(24'h000084);
        snd(24'h00016C);
        snd(24'h000174);
        snd(24'h00001E);
        chk("modc", {modc, seed, mon}, 0);
        snd(24'h2D0918);
        repeat (30) @(posedge c);
        chk("div", {intv, num}, 20'h5A123);
        chk("shadow", {modc, seed}, 33'h1579BDABC);
        chk("fast", {cells, swa, swb, swc, lk_o, mon}, 12'h81D);
        rd(pll_link_pkg::OFS_DATA, d, r);
        chk("last", {r, d}, 34'h2D0918);
        repeat (1000) @(posedge c);
        chk("lock", lk_o, 1);
        repeat (800) @(posedge c);
        chk("slow", {cells, swa, swb, swc, mon}, 11'h010);
        err <= 8'h28;
        repeat (40) @(posedge c);
        chk("loss", lk_o, 0);
        err <= 8'h05;
        snd(24'h00000E);
        chk("mhigh", {mon, lk_o}, 2'h2);
        snd(24'h008016);
        repeat (800) @(posedge c);
        chk("wide", {mon, lk_o}, 2'h3);
        snd(24'h000026);
        @(negedge c) d[0] = mon;
        repeat (8) @(negedge c);
        chk("mpfd", d[0] ^ mon, 1);
        snd(24'h00002E);
        d = 32'h0;
        repeat (128) @(negedge c) d += mon;
        chk("mtick", d, 2);
        wr(32'h8, 32'h0, pll_link_pkg::RESP_SLVERR);
        rd(32'hC, d, r);
        chk("unmap", {r, d}, 34'h200000000);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
